// ---- design/hpp_defs.svh ----
// named constants for the host parallel port
// assumes inclusion by bare name from package and modules
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH
`define HPP_DATA_W 16
`define HPP_ADDR_W 3
`define HPP_SEL_MSB 1
`define HPP_NCHAN 4
`define HPP_ADDR_HOLD 2'h0
`define HPP_ADDR_IRQLEN 2'h1
`define HPP_ADDR_MARK 2'h2
`define HPP_ADDR_CHAN 2'h3
`define HPP_ZERO16 16'h0000
`define HPP_ONE16 16'h0001
`define HPP_IRQLEN_RST 16'h0001
`define HPP_MARK_RST 16'h0000
`define HPP_CHAN_RST 16'h0000
`define HPP_MK_POL_BIT 0
`define HPP_MK_KIND_LSB 1
`define HPP_MK_KIND_MSB 2
`define HPP_MK_POS_LSB 3
`define HPP_MK_POS_MSB 6
`define HPP_CH_MSB 1
`define HPP_POS_W 4
`define HPP_MARK_DEPTH 16
`define HPP_POS_ZERO 4'h0
`define HPP_POS_ONE 4'h1
`define HPP_KIND_WORD 2'h0
`define HPP_KIND_FRAME 2'h1
`define HPP_DLY_RST 16'h0000
`endif

// ---- design/hpp_pkg.sv ----
// types shared by the host parallel port modules
// assumes hpp_defs.svh on the include path
`include "hpp_defs.svh"
package hpp_pkg;
  typedef logic [`HPP_DATA_W-1:0] hpp_word_t;
  typedef struct packed {
    logic cs_n;
    logic strobe_n;
    logic rd_rw;
    logic mode;
    logic [`HPP_ADDR_W-1:0] addr;
    hpp_word_t data;
  } hpp_host_in_t;
  typedef struct packed {
    hpp_word_t data;
    logic oe;
  } hpp_host_out_t;
  typedef struct packed {
    logic [`HPP_POS_W-1:0] pos;
    logic [1:0] kind;
    logic polarity;
  } hpp_mark_cfg_t;
  typedef enum logic [1:0] {
    HPP_IDLE = 2'b00,
    HPP_READ = 2'b01,
    HPP_WRITE = 2'b10
  } hpp_state_t;
endpackage

// ---- design/hpp_marker.sv ----
// word/frame sync marker with programmable polarity and delay
// assumes start pulses from the serial output framer, one clock wide
`timescale 1ns/10ps
`include "hpp_defs.svh"
module hpp_marker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire hpp_pkg::hpp_mark_cfg_t cfg_i,
  input wire logic word_start_i,
  input wire logic frame_start_i,
  output logic marker_o
);
  import hpp_pkg::*;

  logic pulse;
  logic tap;
  logic [`HPP_MARK_DEPTH-1:0] dly_reg;

  // source select: word, frame, or both
  always_comb begin
    case (cfg_i.kind)
      `HPP_KIND_WORD: pulse = word_start_i;
      `HPP_KIND_FRAME: pulse = frame_start_i;
      default: pulse = word_start_i | frame_start_i;
    endcase
  end

  // position: tap of the delay line
  always_comb begin
    if (cfg_i.pos == `HPP_POS_ZERO) begin
      tap = pulse;
    end else begin
      tap = dly_reg[cfg_i.pos - `HPP_POS_ONE];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dly_reg <= `HPP_DLY_RST;
    end else if (clk_en_i) begin
      dly_reg <= {dly_reg[`HPP_MARK_DEPTH-2:0], pulse};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      marker_o <= 1'b0;
    end else if (clk_en_i) begin
      marker_o <= tap ^ cfg_i.polarity;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  marker_pos_zero_a: assert property (
    (clk_en_i && cfg_i.pos == 4'h0 && cfg_i.kind == 2'h0)
      |=> marker_o == ($past(word_start_i) ^ $past(cfg_i.polarity)))
    else $error("marker does not follow word start");

  marker_delay_a: assert property (
    (clk_en_i && cfg_i.pos == 4'h2 && cfg_i.kind == 2'h1 && frame_start_i)
      ##1 (clk_en_i && $stable(cfg_i))[*2]
      |=> marker_o == !cfg_i.polarity)
    else $error("delayed frame marker missing");
endmodule // hpp_marker

// ---- design/hpp_port.sv ----
// host parallel port: strobe decode, write holding, readback, new-data irq
// assumes host pins already synchronous to ref_clk_i; pad pull-down on mode
`timescale 1ns/10ps
`include "hpp_defs.svh"
module hpp_port (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire hpp_pkg::hpp_host_in_t host_i,
  output hpp_pkg::hpp_host_out_t host_o,
  input wire logic [`HPP_NCHAN-1:0] chan_valid_i,
  input wire hpp_pkg::hpp_word_t [`HPP_NCHAN-1:0] chan_word_i,
  input wire logic word_start_i,
  input wire logic frame_start_i,
  output logic new_data_irq_o,
  output logic word_frame_marker_d_o
);
  import hpp_pkg::*;

  hpp_state_t state_reg;
  hpp_state_t state_next;
  hpp_word_t wdata_reg;
  hpp_word_t hold_reg;
  hpp_word_t irqlen_reg;
  hpp_word_t mark_reg;
  hpp_word_t chan_reg;
  hpp_word_t latest_reg;
  hpp_word_t irq_cnt_reg;
  hpp_word_t read_word;
  hpp_mark_cfg_t mark_cfg;
  logic [`HPP_SEL_MSB:0] sel;
  logic [`HPP_CH_MSB:0] chan_sel;
  logic rd_now;
  logic wr_low_now;
  logic wr_commit;
  logic new_event;

  // read request decode for both strobe modes
  function automatic logic rd_active(input hpp_host_in_t h);
    if (h.cs_n) begin
      return 1'b0;
    end
    if (h.mode) begin
      return !h.strobe_n && h.rd_rw;
    end
    return !h.rd_rw;
  endfunction

  // write strobe low decode for both strobe modes
  function automatic logic wr_low(input hpp_host_in_t h);
    if (h.cs_n || h.strobe_n) begin
      return 1'b0;
    end
    if (h.mode) begin
      return !h.rd_rw;
    end
    return h.rd_rw;
  endfunction

  assign rd_now = rd_active(host_i);
  assign wr_low_now = wr_low(host_i);
  assign sel = host_i.addr[`HPP_SEL_MSB:0];
  assign chan_sel = chan_reg[`HPP_CH_MSB:0];
  assign new_event = chan_valid_i[chan_sel];

  // write completes on the strobe returning high while still selected
  assign wr_commit = clk_en_i && (state_reg == HPP_WRITE) && !host_i.cs_n
                     && host_i.strobe_n;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HPP_IDLE: begin
        if (rd_now) begin
          state_next = HPP_READ;
        end else if (wr_low_now) begin
          state_next = HPP_WRITE;
        end
      end
      HPP_READ: begin
        if (!rd_now) begin
          state_next = HPP_IDLE;
        end
      end
      HPP_WRITE: begin
        if (host_i.cs_n || host_i.strobe_n) begin
          state_next = HPP_IDLE;
        end
      end
      default: state_next = HPP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= HPP_IDLE;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  // capture bus data while the strobe is low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wdata_reg <= `HPP_ZERO16;
    end else if (clk_en_i && wr_low_now) begin
      wdata_reg <= host_i.data;
    end
  end

  // holding register loaded only from the bus
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_reg <= `HPP_ZERO16;
    end else if (wr_commit && sel == `HPP_ADDR_HOLD) begin
      hold_reg <= wdata_reg;
    end
  end

  // target registers loaded only from the holding register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irqlen_reg <= `HPP_IRQLEN_RST;
      mark_reg <= `HPP_MARK_RST;
      chan_reg <= `HPP_CHAN_RST;
    end else if (wr_commit) begin
      case (sel)
        `HPP_ADDR_IRQLEN: irqlen_reg <= hold_reg;
        `HPP_ADDR_MARK: mark_reg <= hold_reg;
        `HPP_ADDR_CHAN: chan_reg <= hold_reg;
        default: begin
        end
      endcase
    end
  end

  // latest output word of the selected channel
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      latest_reg <= `HPP_ZERO16;
    end else if (clk_en_i && new_event) begin
      latest_reg <= chan_word_i[chan_sel];
    end
  end

  // readback mux
  always_comb begin
    case (sel)
      `HPP_ADDR_HOLD: read_word = hold_reg;
      `HPP_ADDR_IRQLEN: read_word = irqlen_reg;
      `HPP_ADDR_MARK: read_word = mark_reg;
      default: read_word = latest_reg;
    endcase
  end

  // bus driver: data and enable from flops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      host_o.oe <= 1'b0;
      host_o.data <= `HPP_ZERO16;
    end else if (clk_en_i) begin
      host_o.oe <= rd_now;
      host_o.data <= rd_now ? read_word : `HPP_ZERO16;
    end
  end

  // interrupt length counter, zero length treated as one
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_cnt_reg <= `HPP_ZERO16;
    end else if (clk_en_i) begin
      if (new_event) begin
        irq_cnt_reg <= (irqlen_reg == `HPP_ZERO16) ? `HPP_ONE16 : irqlen_reg;
      end else if (irq_cnt_reg != `HPP_ZERO16) begin
        irq_cnt_reg <= irq_cnt_reg - `HPP_ONE16;
      end
    end
  end

  assign new_data_irq_o = (irq_cnt_reg != `HPP_ZERO16);

  assign mark_cfg.polarity = mark_reg[`HPP_MK_POL_BIT];
  assign mark_cfg.kind = mark_reg[`HPP_MK_KIND_MSB:`HPP_MK_KIND_LSB];
  assign mark_cfg.pos = mark_reg[`HPP_MK_POS_MSB:`HPP_MK_POS_LSB];

  hpp_marker u_marker (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .cfg_i(mark_cfg),
    .word_start_i(word_start_i),
    .frame_start_i(frame_start_i),
    .marker_o(word_frame_marker_d_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ds_write_low_s;
    clk_en_i && state_reg == HPP_IDLE && !host_i.cs_n && host_i.mode
      && !host_i.strobe_n && !host_i.rd_rw;
  endsequence

  sequence ds_write_rise_s;
    clk_en_i && !host_i.cs_n && host_i.strobe_n && sel == 2'h0;
  endsequence

  hold_load_a: assert property (
    (wr_commit && sel == 2'h0) |=> hold_reg == $past(wdata_reg))
    else $error("holding register not loaded");

  target_move_a: assert property (
    (wr_commit && sel == 2'h1) |=> irqlen_reg == $past(hold_reg))
    else $error("target not loaded from holding register");

  target_keep_a: assert property (
    !wr_commit |=> $stable(irqlen_reg) && $stable(mark_reg) && $stable(chan_reg))
    else $error("target changed without write");

  sep_write_a: assert property (
    (clk_en_i && state_reg == HPP_IDLE && !host_i.cs_n && !host_i.mode
      && !host_i.strobe_n && host_i.rd_rw)
      ##1 (clk_en_i && !host_i.cs_n && host_i.strobe_n && sel == 2'h0)
      |=> hold_reg == $past(host_i.data, 2))
    else $error("separate strobe write lost");

  abort_write_a: assert property (
    (clk_en_i && state_reg == HPP_WRITE && host_i.cs_n)
      |=> state_reg == HPP_IDLE && $stable(hold_reg))
    else $error("write done without chip select");

  ds_write_a: assert property (
    ds_write_low_s ##1 ds_write_rise_s |=> hold_reg == $past(wdata_reg))
    else $error("data strobe write lost");

  sep_read_a: assert property (
    (clk_en_i && !host_i.cs_n && !host_i.mode && !host_i.rd_rw)
      |=> host_o.oe && host_o.data == $past(read_word))
    else $error("separate read not driven");

  ds_read_a: assert property (
    (clk_en_i && !host_i.cs_n && host_i.mode && !host_i.strobe_n && host_i.rd_rw)
      |=> host_o.oe)
    else $error("data strobe read not driven");

  bus_release_a: assert property (
    (clk_en_i && (host_i.cs_n || (host_i.mode && host_i.strobe_n))) |=> !host_o.oe)
    else $error("bus driven outside read");

  irq_start_a: assert property (
    (clk_en_i && new_event) |=> new_data_irq_o)
    else $error("interrupt not raised");

  irq_length_a: assert property (
    (clk_en_i && new_event && irqlen_reg == 16'h0002)
      ##1 (clk_en_i && !new_event)[*2] |=> !new_data_irq_o)
    else $error("interrupt length wrong");
endmodule // hpp_port

// ---- test/hpp_host_model.sv ----
// host processor model driving the parallel port pins
// assumes it is driven from tb at falling edges of ref_clk_i
`timescale 1ns/10ps
module hpp_host_model (
  input wire logic ref_clk_i,
  input wire hpp_pkg::hpp_host_out_t dev_i,
  output hpp_pkg::hpp_host_in_t bus_o
);
  import hpp_pkg::*;
  logic cs_n = 1'b1;
  logic strobe_n = 1'b1;
  logic rd_rw = 1'b1;
  logic mode = 1'b0;
  logic [2:0] addr = 3'h0;
  hpp_word_t drv = 16'h0000;
  logic drv_en = 1'b0;
  hpp_word_t wire_data;
  // wire level; a released bus shows the inverse of the last drive
  assign wire_data = dev_i.oe ? dev_i.data : (drv_en ? drv : ~drv);
  assign bus_o = {cs_n, strobe_n, rd_rw, mode, addr, wire_data};
  task automatic wr(input logic m, input logic sel_n, input logic [2:0] a, input hpp_word_t d);
    @(negedge ref_clk_i);
    mode = m;
    addr = a;
    cs_n = sel_n;
    drv = d;
    drv_en = 1'b1;
    rd_rw = ~m;
    strobe_n = 1'b0;
    @(negedge ref_clk_i);
    strobe_n = 1'b1;
    @(negedge ref_clk_i);
    cs_n = 1'b1;
    drv_en = 1'b0;
    rd_rw = 1'b1;
  endtask
  // write whose select is dropped while the strobe is still low
  task automatic wr_cut(input logic m, input hpp_word_t d);
    @(negedge ref_clk_i);
    mode = m;
    addr = 3'h0;
    cs_n = 1'b0;
    drv = d;
    drv_en = 1'b1;
    rd_rw = ~m;
    strobe_n = 1'b0;
    @(negedge ref_clk_i);
    cs_n = 1'b1;
    @(negedge ref_clk_i);
    strobe_n = 1'b1;
    drv_en = 1'b0;
    rd_rw = 1'b1;
  endtask
  task automatic rd(input logic m, input logic [2:0] a, output hpp_word_t q, output logic ok);
    @(negedge ref_clk_i);
    mode = m;
    addr = a;
    cs_n = 1'b0;
    rd_rw = m;
    strobe_n = ~m;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge ref_clk_i);
      ok = (dev_i.oe === 1'b1);
    end
    q = dev_i.data;
    cs_n = 1'b1;
    rd_rw = 1'b1;
    strobe_n = 1'b1;
  endtask
endmodule // hpp_host_model

// ---- test/tb.sv ----
// self-checking bench for the host parallel port
// assumes hpp_host_model as the processor on the host pins
`timescale 1ns/10ps
module tb;
  import hpp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] chan_valid = 4'h0;
  hpp_word_t [3:0] chan_word = {4{16'h0000}};
  logic word_start = 1'b0;
  logic frame_start = 1'b0;
  hpp_host_in_t host_in;
  hpp_host_out_t host_out;
  logic irq;
  logic marker;
  int errors = 0;
  int n_compared = 0;
  hpp_word_t q;
  hpp_word_t l0;
  hpp_word_t l1;
  logic ok;
  initial forever #20 ref_clk_i = ~ref_clk_i;
  hpp_port u_dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en),
    .host_i(host_in),
    .host_o(host_out),
    .chan_valid_i(chan_valid),
    .chan_word_i(chan_word),
    .word_start_i(word_start),
    .frame_start_i(frame_start),
    .new_data_irq_o(irq),
    .word_frame_marker_d_o(marker)
  );
  hpp_host_model u_host (
    .ref_clk_i(ref_clk_i),
    .dev_i(host_out),
    .bus_o(host_in)
  );
  task automatic check(input string name, input hpp_word_t seen, input hpp_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd_chk(input string name, input logic m, input logic [2:0] a, input hpp_word_t e);
    u_host.rd(m, a, q, ok);
    if (!ok) begin
      errors++;
      give_verdict();
    end
    check(name, q, e);
    @(negedge ref_clk_i);
    check("oe after read", {15'h0000, host_out.oe}, 16'h0000);
  endtask
  task automatic set(input logic m, input logic [2:0] a, input hpp_word_t d);
    u_host.wr(m, 1'b0, 3'h0, d);
    u_host.wr(m, 1'b0, a, ~d);
    @(negedge ref_clk_i);
  endtask
  task automatic s_reset();
    check("irq idle", {15'h0000, irq}, 16'h0000);
    rd_chk("irq length", 1'b0, 3'h1, 16'h0001);
    rd_chk("holding", 1'b0, 3'h0, 16'h0000);
    rd_chk("marker cfg", 1'b0, 3'h2, 16'h0000);
  endtask
  task automatic s_modes();
    hpp_word_t v;
    for (int m = 0; m < 2; m++) begin
      v = 16'hA5A5 ^ {16{m[0]}};
      u_host.wr(m[0], 1'b0, 3'h4, v);
      rd_chk("holding", m[0], 3'h0, v);
      rd_chk("irq length alias", m[0], 3'h5, 16'h0001);
      u_host.wr(m[0], 1'b1, 3'h0, 16'h0F0F);
      rd_chk("holding after deselected write", m[0], 3'h0, v);
      u_host.wr(m[0], 1'b0, 3'h1, ~v);
      rd_chk("irq length copy", m[0], 3'h1, v);
      u_host.wr(m[0], 1'b0, 3'h0, 16'h0001);
      u_host.wr(m[0], 1'b0, 3'h1, 16'h5A5A);
    end
  endtask
  task automatic irq_count(input int ch, input hpp_word_t e);
    hpp_word_t n;
    n = 16'h0000;
    @(negedge ref_clk_i);
    chan_valid[ch] = 1'b1;
    @(negedge ref_clk_i);
    chan_valid[ch] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (irq === 1'b1) n++;
      @(negedge ref_clk_i);
    end
    check("irq cycles", n, e);
  endtask
  task automatic s_irq();
    chan_word[2] = 16'h1234;
    chan_word[0] = 16'h4321;
    set(1'b0, 3'h3, 16'h0002);
    set(1'b0, 3'h1, 16'h0003);
    irq_count(2, 16'h0003);
    irq_count(0, 16'h0000);
    rd_chk("channel word", 1'b0, 3'h3, 16'h1234);
    set(1'b1, 3'h1, 16'h0000);
    irq_count(2, 16'h0001);
    set(1'b0, 3'h1, 16'h0002);
    irq_count(2, 16'h0002);
  endtask
  task automatic s_freeze();
    u_host.wr_cut(1'b0, 16'h3C3C);
    rd_chk("holding after cut write", 1'b0, 3'h0, 16'h0002);
    @(negedge ref_clk_i);
    clk_en = 1'b0;
    u_host.wr(1'b0, 1'b0, 3'h0, 16'h7777);
    clk_en = 1'b1;
    rd_chk("holding after frozen write", 1'b0, 3'h0, 16'h0002);
  endtask
  task automatic mark_lat(input logic [1:0] src, output hpp_word_t lat);
    logic base;
    base = marker;
    lat = 16'h0000;
    @(negedge ref_clk_i);
    word_start = src[0];
    frame_start = src[1];
    @(negedge ref_clk_i);
    word_start = 1'b0;
    frame_start = 1'b0;
    while (marker === base && lat < 16'h0014) begin
      @(negedge ref_clk_i);
      lat++;
    end
    @(negedge ref_clk_i);
    check("marker width", {15'h0000, marker}, {15'h0000, base});
  endtask
  task automatic s_marker();
    set(1'b0, 3'h2, 16'h0001);
    check("marker idle", {15'h0000, marker}, 16'h0001);
    mark_lat(2'b01, l0);
    set(1'b0, 3'h2, 16'h0019);
    mark_lat(2'b01, l1);
    check("marker delay", l1 - l0, 16'h0003);
    set(1'b0, 3'h2, 16'h0002);
    mark_lat(2'b01, l1);
    check("marker word ignored", l1, 16'h0014);
    mark_lat(2'b10, l1);
    check("marker frame", l1, l0);
    set(1'b0, 3'h2, 16'h0012);
    mark_lat(2'b10, l1);
    check("marker frame delay", l1, 16'h0002);
    set(1'b0, 3'h2, 16'h0004);
    mark_lat(2'b01, l1);
    check("marker both word", l1, 16'h0000);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    s_reset();
    s_modes();
    s_irq();
    s_freeze();
    s_marker();
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rd_chk("irq length after reset", 1'b1, 3'h1, 16'h0001);
    give_verdict();
  end
endmodule // tb
